// file: rtl/osd_command_decoder.sv
// serial command decoder for the on-screen display controller
`default_nettype none
module osd_command_decoder
	import osd_cmd_pkg::*;
#(
	parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// serial pins
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        sdata_i,
	// write positions
	output logic [3:0]       line_addr_o,
	output logic [5:0]       column_addr_o,
	output logic             sub_line_o,
	output logic             sub_column_o,
	// stored command registers
	output logic [7:0]       system_control_o,
	output logic [7:0]       display_control_o,
	output logic [7:0]       polarity_one_o,
	// decoded settings
	output logic             independent_sel_o,
	output logic             resolution_sel_o,
	output logic             register_clear_o,
	output logic             display_off_state_o,
	output logic             osc_stop_inhibit_o,
	output logic [1:0]       blink_period_o,
	output logic             backdrop_enable_o,
	output logic             wallpaper_enable_o,
	output logic             main_layer_enable_o,
	// erase strobes
	output logic             palette_erase_o,
	output logic             screen_mem_erase_a_o,
	output logic             screen_mem_erase_b_o,
	output logic             erase_busy_o,
	// cell write
	output logic             cell_write_o,
	output logic             cell_sub_o,
	output logic [3:0]       cell_line_o,
	output logic [5:0]       cell_column_o,
	output logic             blink_enable_o,
	output logic             box_style_o,
	output logic             box_left_edge_o,
	output logic             box_right_edge_o,
	output logic             box_top_edge_o,
	output logic             box_bottom_edge_o,
	output logic [3:0]       cell_bg_colour_o,
	output logic [3:0]       cell_fg_colour_o,
	output logic             palette_select_o,
	output logic             ext_glyph_o,
	output logic             graphic_glyph_o,
	output logic [10:0]      glyph_code_o,
	output logic             transparent_o
);

	// ******************************************************
	// helpers
	// ******************************************************
	function automatic logic cmd_match(input logic [7:0] b, input logic [7:0] val,
			input logic [7:0] mask);
		cmd_match = ((b & mask) == val);
	endfunction : cmd_match

	// ******************************************************
	// pin synchronisers
	// ******************************************************
	logic cs_meta;
	logic cs_sync;
	logic sclk_meta;
	logic sclk_sync;
	logic sclk_prev;
	logic sdata_meta;
	logic sdata_sync;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cs_meta    <= 1'b1;
			cs_sync    <= 1'b1;
			sclk_meta  <= 1'b0;
			sclk_sync  <= 1'b0;
			sclk_prev  <= 1'b0;
			sdata_meta <= 1'b0;
			sdata_sync <= 1'b0;
		end else begin
			cs_meta    <= cs_n_i;
			cs_sync    <= cs_meta;
			sclk_meta  <= sclk_i;
			sclk_sync  <= sclk_meta;
			sclk_prev  <= sclk_sync;
			sdata_meta <= sdata_i;
			sdata_sync <= sdata_meta;
		end
	end

	// ******************************************************
	// byte shifter, msb first on rising serial clock
	// ******************************************************
	logic [2:0] bit_cnt;
	logic [6:0] shift;
	logic       byte_vld;
	logic [7:0] rx_byte;

	// frame end flushes a partial byte so the next frame starts aligned
	always_ff @(posedge clk_i) begin
		if (srst_i || cs_sync) begin
			bit_cnt  <= 3'h0;
			shift    <= 7'h00;
			byte_vld <= 1'b0;
			rx_byte  <= 8'h00;
		end else begin
			byte_vld <= 1'b0;
			if (sclk_sync && !sclk_prev) begin
				shift   <= {shift[5:0], sdata_sync};
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					rx_byte  <= {shift, sdata_sync};
					byte_vld <= 1'b1;
				end
			end
		end
	end

	// ******************************************************
	// frame state
	// ******************************************************
	frame_state_e state;
	opcode_e      opcode;
	logic         char_sub;
	logic [1:0]   seq_mode;
	logic [1:0]   slot;
	logic         clear_hold;
	logic         first_vld;
	logic         second_vld;
	logic         char_vld;
	logic         cell_done;
	logic         clear_now;

	assign first_vld  = byte_vld && (state == ST_FIRST);
	assign second_vld = byte_vld && (state == ST_SECOND);
	assign char_vld   = byte_vld && (state == ST_CHAR);
	assign cell_done  = char_vld && (slot == SLOT_CODE_LO);
	assign clear_now  = second_vld && (opcode == OP_SYSTEM)
		&& rx_byte[SYS_REGISTER_CLEAR];

	always_ff @(posedge clk_i) begin
		if (srst_i || cs_sync) begin
			state    <= ST_FIRST;
			opcode   <= OP_MAIN_ADDR;
			char_sub <= 1'b0;
			seq_mode <= SEQ_ONCE;
			slot     <= SLOT_ATTR1;
		end else if (first_vld) begin
			state <= ST_SECOND;
			if (cmd_match(rx_byte, CMD_MAIN_ADDR, CMD_MAIN_ADDR_MASK)) begin
				opcode <= OP_MAIN_ADDR;
			end else if (cmd_match(rx_byte, CMD_SUB_ADDR, CMD_EXACT_MASK)) begin
				opcode <= OP_SUB_ADDR;
			end else if (cmd_match(rx_byte, CMD_MAIN_CHAR, CMD_CHAR_MASK)) begin
				state    <= ST_CHAR;
				char_sub <= 1'b0;
				seq_mode <= rx_byte[1:0];
				slot     <= SLOT_ATTR1;
			end else if (cmd_match(rx_byte, CMD_SUB_CHAR, CMD_CHAR_MASK)) begin
				state    <= ST_CHAR;
				char_sub <= 1'b1;
				seq_mode <= rx_byte[1:0];
				slot     <= SLOT_ATTR1;
			end else if (cmd_match(rx_byte, CMD_SYSTEM, CMD_EXACT_MASK)) begin
				opcode <= OP_SYSTEM;
			end else if (cmd_match(rx_byte, CMD_DISPLAY, CMD_EXACT_MASK)) begin
				opcode <= OP_DISPLAY;
			end else if (cmd_match(rx_byte, CMD_POLARITY_ONE, CMD_EXACT_MASK)) begin
				opcode <= OP_POLARITY_ONE;
			end else begin
				state <= ST_IGNORE;
			end
		end else if (second_vld) begin
			// one parameter byte per command; extras wait for deselect
			state <= ST_IGNORE;
		end else if (char_vld) begin
			if (slot != SLOT_CODE_LO) begin
				slot <= slot + 2'h1;
			end else begin
				case (seq_mode)
					SEQ_ONCE:   state <= ST_IGNORE;
					SEQ_ALL:    slot  <= SLOT_ATTR1;
					SEQ_FROM_3: slot  <= SLOT_CODE_HI;
					default:    slot  <= SLOT_ATTR2;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || cs_sync) begin
			clear_hold <= 1'b0;
		end else if (clear_now) begin
			clear_hold <= 1'b1;
		end
	end

	// ******************************************************
	// command registers
	// ******************************************************
	logic [3:0] line_addr;
	logic [5:0] column_addr;
	logic       sub_line;
	logic       sub_column;
	logic [7:0] system_control;
	logic [7:0] display_control;
	logic [7:0] polarity_one;
	logic       osc_inhibit_eff;
	logic       display_off;
	logic       advance;
	logic [3:0] line_limit;
	logic [5:0] col_limit;

	assign display_off = !display_control[DISP_BACKDROP] && !display_control[DISP_WALLPAPER]
		&& !display_control[DISP_MAIN_LAYER];
	assign line_limit  = system_control[SYS_RESOLUTION] ? LINES_WVGA : LINES_QVGA;
	assign col_limit   = system_control[SYS_RESOLUTION] ? COLS_WVGA : COLS_QVGA;
	assign advance     = cell_done && (seq_mode != SEQ_ONCE);

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_now || clear_hold) begin
			system_control  <= REG_RESET;
			display_control <= REG_RESET;
			polarity_one    <= REG_RESET;
		end else if (second_vld) begin
			case (opcode)
				OP_SYSTEM:       system_control  <= rx_byte;
				OP_DISPLAY:      display_control <= rx_byte;
				OP_POLARITY_ONE: polarity_one    <= rx_byte;
				default:         ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_now || clear_hold) begin
			line_addr   <= 4'h0;
			column_addr <= 6'h00;
			sub_line    <= 1'b0;
			sub_column  <= 1'b0;
		end else if (first_vld
				&& cmd_match(rx_byte, CMD_MAIN_ADDR, CMD_MAIN_ADDR_MASK)) begin
			line_addr[3:2] <= rx_byte[1:0];
		end else if (second_vld && opcode == OP_MAIN_ADDR) begin
			line_addr[1:0] <= rx_byte[7:6];
			column_addr    <= rx_byte[5:0];
		end else if (second_vld && opcode == OP_SUB_ADDR) begin
			sub_line   <= rx_byte[SUB_LINE_BIT];
			sub_column <= rx_byte[SUB_COLUMN_BIT];
		end else if (advance && char_sub) begin
			sub_column <= !sub_column;
			if (sub_column) begin
				sub_line <= !sub_line;
			end
		end else if (advance) begin
			if (column_addr >= col_limit - 6'h01) begin
				column_addr <= 6'h00;
				line_addr   <= (line_addr >= line_limit - 4'h1) ? 4'h0 : line_addr + 4'h1;
			end else begin
				column_addr <= column_addr + 6'h01;
			end
		end
	end

	// inhibit follows only with display off
	always_ff @(posedge clk_i) begin
		if (srst_i || clear_now || clear_hold) begin
			osc_inhibit_eff <= 1'b0;
		end else if (display_off) begin
			osc_inhibit_eff <= display_control[DISP_OSC_INHIBIT];
		end
	end

	// ******************************************************
	// erase strobes and wait window
	// ******************************************************
	logic        pal_erase;
	logic        mem_erase_a;
	logic        mem_erase_b;
	logic [31:0] erase_cnt;
	logic        any_erase;

	assign any_erase = second_vld && (opcode == OP_SYSTEM) && !rx_byte[SYS_REGISTER_CLEAR]
		&& (rx_byte[SYS_PALETTE_ERASE] || rx_byte[SYS_MEM_ERASE_B] || rx_byte[SYS_MEM_ERASE_A]);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pal_erase   <= 1'b0;
			mem_erase_a <= 1'b0;
			mem_erase_b <= 1'b0;
		end else begin
			pal_erase   <= any_erase && rx_byte[SYS_PALETTE_ERASE];
			mem_erase_b <= any_erase && rx_byte[SYS_MEM_ERASE_B];
			mem_erase_a <= any_erase && rx_byte[SYS_MEM_ERASE_A];
		end
	end

	// busy is advisory; the host is still expected to wait itself
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			erase_cnt <= 32'h0;
		end else if (any_erase) begin
			erase_cnt <= 32'(ERASE_WAIT);
		end else if (erase_cnt != 32'h0) begin
			erase_cnt <= erase_cnt - 32'h1;
		end
	end

	// ******************************************************
	// character cell assembly
	// ******************************************************
	logic [7:0] attr1;
	logic [7:0] attr2;
	logic [7:0] code_hi;
	logic       cell_write;
	logic       cell_sub;
	logic [3:0] cell_line;
	logic [5:0] cell_column;
	logic [7:0] cell_attr1;
	logic [7:0] cell_attr2;
	logic [7:0] cell_code_hi;
	logic [7:0] cell_code_lo;

	always_ff @(posedge clk_i) begin
		if (srst_i || clear_hold) begin
			attr1   <= 8'h00;
			attr2   <= 8'h00;
			code_hi <= 8'h00;
		end else if (char_vld) begin
			case (slot)
				SLOT_ATTR1:   attr1   <= rx_byte;
				SLOT_ATTR2:   attr2   <= rx_byte;
				SLOT_CODE_HI: code_hi <= rx_byte;
				default:      ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cell_write   <= 1'b0;
			cell_sub     <= 1'b0;
			cell_line    <= 4'h0;
			cell_column  <= 6'h00;
			cell_attr1   <= 8'h00;
			cell_attr2   <= 8'h00;
			cell_code_hi <= 8'h00;
			cell_code_lo <= 8'h00;
		end else begin
			cell_write <= cell_done && !clear_hold;
			if (cell_done) begin
				cell_sub     <= char_sub;
				cell_line    <= char_sub ? {3'h0, sub_line} : line_addr;
				cell_column  <= char_sub ? {5'h00, sub_column} : column_addr;
				cell_attr1   <= char_sub ? 8'h00 : attr1;
				cell_attr2   <= char_sub ? 8'h00 : attr2;
				cell_code_hi <= code_hi;
				cell_code_lo <= rx_byte;
			end
		end
	end

	// ******************************************************
	// outputs
	// ******************************************************
	assign line_addr_o          = line_addr;
	assign column_addr_o        = column_addr;
	assign sub_line_o           = sub_line;
	assign sub_column_o         = sub_column;
	assign system_control_o     = system_control;
	assign display_control_o    = display_control;
	assign polarity_one_o       = polarity_one;
	assign independent_sel_o    = system_control[SYS_INDEPENDENT];
	assign resolution_sel_o     = system_control[SYS_RESOLUTION];
	assign register_clear_o     = clear_hold;
	assign display_off_state_o  = display_off;
	assign osc_stop_inhibit_o   = osc_inhibit_eff;
	assign blink_period_o       = {display_control[DISP_BLINK_HI], display_control[DISP_BLINK_LO]};
	assign backdrop_enable_o    = display_control[DISP_BACKDROP];
	assign wallpaper_enable_o   = display_control[DISP_WALLPAPER];
	assign main_layer_enable_o  = display_control[DISP_MAIN_LAYER];
	assign palette_erase_o      = pal_erase;
	assign screen_mem_erase_a_o = mem_erase_a;
	assign screen_mem_erase_b_o = mem_erase_b;
	assign erase_busy_o         = (erase_cnt != 32'h0);
	assign cell_write_o         = cell_write;
	assign cell_sub_o           = cell_sub;
	assign cell_line_o          = cell_line;
	assign cell_column_o        = cell_column;
	assign blink_enable_o       = cell_attr1[ATTR_BLINK];
	assign box_style_o          = cell_attr1[ATTR_BOX_STYLE];
	assign box_left_edge_o      = cell_attr1[ATTR_BOX_LEFT];
	assign box_right_edge_o     = cell_attr1[ATTR_BOX_RIGHT];
	assign box_top_edge_o       = cell_attr1[ATTR_BOX_TOP];
	assign box_bottom_edge_o    = cell_attr1[ATTR_BOX_BOTTOM];
	assign cell_bg_colour_o     = cell_attr2[7:4];
	assign cell_fg_colour_o     = cell_attr2[3:0];
	assign palette_select_o     = cell_code_hi[B3_PALETTE];
	assign ext_glyph_o          = cell_code_hi[B3_EXTERNAL];
	assign graphic_glyph_o      = cell_code_hi[B3_GRAPHIC];
	assign glyph_code_o         = {cell_code_hi[2:0], cell_code_lo};
	assign transparent_o        = !cell_code_hi[B3_EXTERNAL] && !cell_code_hi[B3_GRAPHIC]
		&& ({cell_code_hi[2:0], cell_code_lo} == TRANSPARENT_CODE);

endmodule : osd_command_decoder
`default_nettype wire

// file: shared/osd_cmd_pkg.sv
// constants shared by the on-screen display serial command decoder
`default_nettype none
package osd_cmd_pkg;

	// ******************************************************
	// first-byte patterns and masks
	// ******************************************************
	localparam logic [7:0] CMD_MAIN_ADDR      = 8'h80;
	localparam logic [7:0] CMD_MAIN_ADDR_MASK = 8'hFC;
	localparam logic [7:0] CMD_SUB_ADDR       = 8'h84;
	localparam logic [7:0] CMD_MAIN_CHAR      = 8'h90;
	localparam logic [7:0] CMD_SUB_CHAR       = 8'h94;
	localparam logic [7:0] CMD_CHAR_MASK      = 8'hFC;
	localparam logic [7:0] CMD_SYSTEM         = 8'hA0;
	localparam logic [7:0] CMD_DISPLAY        = 8'hA1;
	localparam logic [7:0] CMD_POLARITY_ONE   = 8'hA2;
	localparam logic [7:0] CMD_EXACT_MASK     = 8'hFF;

	// ******************************************************
	// field positions
	// ******************************************************
	localparam int SYS_TEST_SEL_B      = 7;
	localparam int SYS_TEST_SEL_A      = 6;
	localparam int SYS_INDEPENDENT     = 5;
	localparam int SYS_RESOLUTION      = 4;
	localparam int SYS_REGISTER_CLEAR  = 3;
	localparam int SYS_PALETTE_ERASE   = 2;
	localparam int SYS_MEM_ERASE_B     = 1;
	localparam int SYS_MEM_ERASE_A     = 0;
	localparam int DISP_OSC_INHIBIT    = 7;
	localparam int DISP_BLINK_HI       = 6;
	localparam int DISP_BLINK_LO       = 5;
	localparam int DISP_BACKDROP       = 2;
	localparam int DISP_WALLPAPER      = 1;
	localparam int DISP_MAIN_LAYER     = 0;
	localparam int SUB_LINE_BIT        = 6;
	localparam int SUB_COLUMN_BIT      = 0;
	localparam int ATTR_BLINK          = 5;
	localparam int ATTR_BOX_STYLE      = 4;
	localparam int ATTR_BOX_LEFT       = 3;
	localparam int ATTR_BOX_RIGHT      = 2;
	localparam int ATTR_BOX_TOP        = 1;
	localparam int ATTR_BOX_BOTTOM     = 0;
	localparam int B3_PALETTE          = 5;
	localparam int B3_EXTERNAL         = 4;
	localparam int B3_GRAPHIC          = 3;

	// ******************************************************
	// screen geometry, codes and reset values
	// ******************************************************
	localparam logic [3:0]  LINES_QVGA       = 4'hD;
	localparam logic [3:0]  LINES_WVGA       = 4'hF;
	localparam logic [5:0]  COLS_QVGA        = 6'h28;
	localparam logic [5:0]  COLS_WVGA        = 6'h21;
	localparam logic [10:0] TRANSPARENT_CODE = 11'h1FF;
	localparam logic [7:0]  REG_RESET        = 8'h00;

	// sequence mode select values
	localparam logic [1:0] SEQ_ONCE     = 2'h0;
	localparam logic [1:0] SEQ_ALL      = 2'h1;
	localparam logic [1:0] SEQ_FROM_3   = 2'h2;
	localparam logic [1:0] SEQ_FROM_2   = 2'h3;

	// character byte slots, zero based
	localparam logic [1:0] SLOT_ATTR1   = 2'h0;
	localparam logic [1:0] SLOT_ATTR2   = 2'h1;
	localparam logic [1:0] SLOT_CODE_HI = 2'h2;
	localparam logic [1:0] SLOT_CODE_LO = 2'h3;

	// ******************************************************
	// timing
	// ******************************************************
	localparam int CLK_PERIOD_NS  = 25;
	localparam int ERASE_WAIT_NS  = 1000000;
	localparam int ERASE_WAIT_CYC = ERASE_WAIT_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_FIRST,
		ST_SECOND,
		ST_CHAR,
		ST_IGNORE
	} frame_state_e;

	typedef enum logic [2:0] {
		OP_MAIN_ADDR,
		OP_SUB_ADDR,
		OP_SYSTEM,
		OP_DISPLAY,
		OP_POLARITY_ONE
	} opcode_e;

endpackage : osd_cmd_pkg
`default_nettype wire

// file: verification/osd_host_model.sv
// host side serial driver for the osd command decoder
`default_nettype none
module osd_host_model (
	// clock
	input  wire logic clk_i,
	// serial pins
	output var logic  cs_n_o,
	output var logic  sclk_o,
	output var logic  sdata_o
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
	end
	task tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	// ******************************
	// frames, msb first, sclk idle low
	// ******************************
	task send(input logic [7:0] q[$], input bit hold);
		cs_n_o = 1'b0;
		tick(4);
		foreach (q[i]) for (int b = 7; b >= 0; b--) begin
			sdata_o = q[i][b];
			tick(4);
			sclk_o = 1'b1;
			tick(4);
			sclk_o = 1'b0;
		end
		tick(8);
		if (!hold) close();
	endtask : send
	task close();
		cs_n_o = 1'b1;
		// released line shows no stale level
		sdata_o = ~sdata_o;
		tick(12);
	endtask : close
endmodule : osd_host_model
`default_nettype wire

// file: verification/osd_command_decoder_monitor.sv
// assertion checker for the osd command decoder outputs
`default_nettype none
module osd_command_decoder_monitor (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        srst_i,
	// observed outputs
	input wire logic [7:0]  system_control_o,
	input wire logic [7:0]  display_control_o,
	input wire logic [3:0]  line_addr_o,
	input wire logic        independent_sel_o,
	input wire logic        resolution_sel_o,
	input wire logic        register_clear_o,
	input wire logic        display_off_state_o,
	input wire logic        osc_stop_inhibit_o,
	input wire logic [1:0]  blink_period_o,
	input wire logic        backdrop_enable_o,
	input wire logic        wallpaper_enable_o,
	input wire logic        main_layer_enable_o,
	input wire logic        palette_erase_o,
	input wire logic        erase_busy_o,
	input wire logic        cell_write_o,
	input wire logic        cell_sub_o,
	input wire logic        blink_enable_o,
	input wire logic [3:0]  cell_bg_colour_o,
	input wire logic [3:0]  cell_fg_colour_o,
	input wire logic        ext_glyph_o,
	input wire logic        graphic_glyph_o,
	input wire logic [10:0] glyph_code_o,
	input wire logic        transparent_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	// ******************************
	// assertions
	// ******************************
	a_blink_period: assert property (blink_period_o == display_control_o[6:5])
		else $error("blink period differs from display byte");
	a_layer_enables: assert property ({backdrop_enable_o, wallpaper_enable_o,
		main_layer_enable_o} == display_control_o[2:0]) else $error("layer enables wrong");
	a_display_off: assert property (display_off_state_o == (display_control_o[2:0] == 3'h0))
		else $error("display off state wrong");
	a_osc_inhibit: assert property ($changed(osc_stop_inhibit_o) |->
		$past(display_off_state_o) || register_clear_o) else $error("inhibit moved with display on");
	a_mode_fields: assert property ({independent_sel_o, resolution_sel_o} ==
		system_control_o[5:4]) else $error("mode selects wrong");
	a_clear_zeroes: assert property (register_clear_o |-> system_control_o == 8'h00 &&
		display_control_o == 8'h00 && line_addr_o == 4'h0) else $error("clear left a register");
	a_transparent_cell: assert property (cell_write_o |-> transparent_o == (!ext_glyph_o &&
		!graphic_glyph_o && glyph_code_o == 11'h1FF)) else $error("transparent flag wrong");
	a_sub_attr_zero: assert property (cell_write_o && cell_sub_o |-> !blink_enable_o &&
		cell_bg_colour_o == 4'h0 && cell_fg_colour_o == 4'h0) else $error("sub cell attributes");
	a_erase_busy: assert property (palette_erase_o |=> erase_busy_o [*4])
		else $error("erase busy missing");
	a_write_pulse: assert property (cell_write_o |=> !cell_write_o [*8])
		else $error("cell write pulse too long");
	c_cell: cover property (cell_write_o && cell_sub_o);
	c_clear: cover property (register_clear_o);
	c_erase: cover property (palette_erase_o);
endmodule : osd_command_decoder_monitor
bind osd_command_decoder osd_command_decoder_monitor u_mon (.clk_i, .srst_i,
	.system_control_o, .display_control_o, .line_addr_o, .independent_sel_o,
	.resolution_sel_o, .register_clear_o, .display_off_state_o, .osc_stop_inhibit_o,
	.blink_period_o, .backdrop_enable_o, .wallpaper_enable_o, .main_layer_enable_o,
	.palette_erase_o, .erase_busy_o, .cell_write_o, .cell_sub_o, .blink_enable_o,
	.cell_bg_colour_o, .cell_fg_colour_o, .ext_glyph_o, .graphic_glyph_o, .glyph_code_o,
	.transparent_o);
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the osd command decoder
`default_nettype none
module testbench
	import osd_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0, srst_i = 1'b1, cs_n, sclk, sdata;
	logic [7:0] system_control_o, display_control_o, polarity_one_o;
	logic [3:0] line_addr_o, cell_line_o, cell_bg_colour_o, cell_fg_colour_o, np, na, nb;
	logic [5:0] column_addr_o, cell_column_o;
	logic [1:0] blink_period_o;
	logic [10:0] glyph_code_o;
	logic sub_line_o, sub_column_o, independent_sel_o, resolution_sel_o, register_clear_o;
	logic osc_stop_inhibit_o, backdrop_enable_o, wallpaper_enable_o, main_layer_enable_o;
	logic palette_erase_o, screen_mem_erase_a_o, screen_mem_erase_b_o, erase_busy_o;
	logic cell_write_o, cell_sub_o, blink_enable_o, box_style_o, box_left_edge_o;
	logic box_right_edge_o, box_top_edge_o, box_bottom_edge_o, ext_glyph_o, graphic_glyph_o;
	logic transparent_o, palette_select_o, seen_trans = 1'b0;
	logic [15:0] ncells = 16'h0000;
	int fails = 0, compares = 0;
	typedef struct packed {logic [7:0] b1; logic [7:0] b2; logic [2:0] sel; logic [15:0] exp;} row_s;
	row_s rows [11] = '{
		'{CMD_DISPLAY, 8'h07, 3'h0, 16'h0707},
		'{CMD_DISPLAY, 8'hC0, 3'h0, 16'h30C0},
		'{CMD_DISPLAY, 8'h20, 3'h0, 16'h0820},
		'{CMD_DISPLAY, 8'h81, 3'h0, 16'h0181},
		'{8'hA7, 8'h12, 3'h0, 16'h0181},
		'{CMD_SYSTEM, 8'h30, 3'h1, 16'h0330},
		'{CMD_SYSTEM, 8'h00, 3'h1, 16'h0000},
		'{CMD_POLARITY_ONE, 8'h5A, 3'h2, 16'h005A},
		'{8'h83, 8'h45, 3'h3, 16'h0345},
		'{CMD_SUB_ADDR, 8'h41, 3'h4, 16'h0003},
		'{CMD_SUB_ADDR, 8'h40, 3'h4, 16'h0002}};
	always #12.5 clk_i = ~clk_i;
	osd_host_model host (.clk_i, .cs_n_o(cs_n), .sclk_o(sclk), .sdata_o(sdata));
	osd_command_decoder #(.ERASE_WAIT(8)) DUT (.clk_i, .srst_i, .cs_n_i(cs_n), .sclk_i(sclk),
		.sdata_i(sdata), .line_addr_o, .column_addr_o, .sub_line_o, .sub_column_o,
		.system_control_o, .display_control_o, .polarity_one_o, .independent_sel_o,
		.resolution_sel_o, .register_clear_o, .display_off_state_o(), .osc_stop_inhibit_o,
		.blink_period_o, .backdrop_enable_o, .wallpaper_enable_o, .main_layer_enable_o,
		.palette_erase_o, .screen_mem_erase_a_o, .screen_mem_erase_b_o, .erase_busy_o,
		.cell_write_o, .cell_sub_o, .cell_line_o, .cell_column_o, .blink_enable_o, .box_style_o,
		.box_left_edge_o, .box_right_edge_o, .box_top_edge_o, .box_bottom_edge_o,
		.cell_bg_colour_o, .cell_fg_colour_o, .palette_select_o, .ext_glyph_o,
		.graphic_glyph_o, .glyph_code_o, .transparent_o);
	// pulse counters, gated so reset-time unknowns never enter
	always @(posedge clk_i) if (!srst_i) begin
		if (cell_write_o === 1'b1) begin
			ncells <= ncells + 16'h0001;
			seen_trans <= seen_trans | transparent_o;
		end
		np <= np + {3'h0, palette_erase_o};
		na <= na + {3'h0, screen_mem_erase_a_o};
		nb <= nb + {3'h0, screen_mem_erase_b_o};
	end else {np, na, nb} <= 12'h000;
	function automatic logic [15:0] obs(input logic [2:0] sel);
		case (sel)
			3'h0: obs = {2'h0, osc_stop_inhibit_o, blink_period_o, backdrop_enable_o,
				wallpaper_enable_o, main_layer_enable_o, display_control_o};
			3'h1: obs = {6'h00, independent_sel_o, resolution_sel_o, system_control_o};
			3'h2: obs = {8'h00, polarity_one_o};
			3'h3: obs = {6'h00, line_addr_o, column_addr_o};
			default: obs = {14'h0000, sub_line_o, sub_column_o};
		endcase
	endfunction : obs
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task report_and_stop();
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// ******************************
	// table, then awkward cases
	// ******************************
	initial begin
		repeat (6) @(posedge clk_i);
		#1 srst_i = 1'b0;
		host.tick(4);
		chk({system_control_o, display_control_o}, 16'h0000);
		foreach (rows[i]) begin
			host.send('{rows[i].b1, rows[i].b2}, 1'b0);
			chk(obs(rows[i].sel), rows[i].exp);
		end
		host.send('{8'h80, 8'h27}, 1'b0);
		host.send('{8'h91, 8'h3F, 8'hA5, 8'h01, 8'hFF, 8'h20, 8'h3C, 8'h3A, 8'h34}, 1'b0);
		chk(ncells, 16'h0002);
		chk({15'h0000, seen_trans}, 16'h0001);
		chk({7'h00, blink_enable_o, cell_bg_colour_o, cell_fg_colour_o}, 16'h013C);
		chk({2'h0, palette_select_o, ext_glyph_o, graphic_glyph_o, glyph_code_o},
			16'h3A34);
		chk({6'h00, cell_line_o, cell_column_o}, 16'h0040);
		chk(obs(3'h3), 16'h0041);
		host.send('{8'h90, 8'h15, 8'h00, 8'h02, 8'h55, 8'h0F, 8'h0F, 8'h0F, 8'h0F}, 1'b0);
		chk({10'h000, blink_enable_o, box_style_o, box_left_edge_o, box_right_edge_o,
			box_top_edge_o, box_bottom_edge_o}, 16'h0015);
		chk({ncells[11:0], 4'h0} | {5'h00, glyph_code_o}, 16'h0255 | 16'h0030);
		chk(obs(3'h3), 16'h0041);
		host.send('{8'h97, 8'h00, 8'h00, 8'h09, 8'hAB, 8'h00, 8'h08, 8'hCD}, 1'b0);
		host.send('{8'h96, 8'h00, 8'h00, 8'h08, 8'h11, 8'h08, 8'h22}, 1'b0);
		chk({cell_sub_o, ncells[2:0], graphic_glyph_o, glyph_code_o}, 16'hF822);
		chk(obs(3'h4), 16'h0002);
		host.send('{CMD_SYSTEM, 8'h0C, 8'h12}, 1'b1);
		chk({7'h00, register_clear_o, display_control_o}, 16'h0100);
		chk(obs(3'h3), 16'h0000);
		host.close();
		chk({15'h0000, register_clear_o}, 16'h0000);
		host.send('{CMD_SYSTEM, 8'h07}, 1'b0);
		chk({3'h0, erase_busy_o, np, nb, na}, 16'h0111);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
